// ===== common/pcasr_pkg.sv
// Summary of operation
// - Mode pin low makes the block the serial clock master.
// - Master clock starts after a conversion, giving exactly 24 falling/rising edges.
// - Data/ready line rests high, goes low when a new result exists.
// - Data changes after a falling clock edge, sampled on the next rising.
// - Master clock holds high after the 24th bit until the next result.
// - After the word, data/ready returns high until another result exists.
// - Converts while select low; clock and data lines released when select high.
// - Pair select low converts pair one, high converts pair two.
// - After a pair change no result is offered until settling passes.
// - Range low gives gain 16, range high gives gain 1.
// - Results are 24-bit offset binary, midscale code at zero input.
// - Code equals two to 23 times one plus scaled input.
// - Converter clock is the crystal rate multiplied up to 4.194304 MHz.
// - Modulator samples at the crystal rate.
// - Result rate is crystal rate over 69 times 8 times 3.
// - Settling time is two result periods.
// - Select high aborts, stands by, drops the result; low restarts.
// - Data/ready goes high before the output register is updated.
package pcasr_pkg;
    localparam int RES_W = 24;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_HZ = 40000000;
    localparam int XTAL_HZ = 32768;
    localparam int PLL_HZ = 4194304;
    localparam int PLL_MULT = PLL_HZ / XTAL_HZ;
    localparam int DEC_A = 69;
    localparam int DEC_B = 8;
    localparam int DEC_C = 3;
    localparam int CONV_DIV = DEC_A * DEC_B * DEC_C;
    localparam int CONV_CYC_DEF =
        int'(longint'(CLK_HZ) * longint'(CONV_DIV) / longint'(XTAL_HZ));
    localparam int MOD_CYC = CLK_HZ / XTAL_HZ;
    localparam int LOCK_NS = 100000;
    localparam int LOCK_CYC = int'(longint'(LOCK_NS) * CLK_HZ / 1000000000);
    localparam int SCLK_HALF_NS = 2000;
    localparam int HALF_CYC =
        int'(longint'(SCLK_HALF_NS) * CLK_HZ / 1000000000);
    localparam logic [1:0] SETTLE_PERIODS = 2'h2;
    localparam logic [4:0] GAIN_NARROW = 5'h10;
    localparam logic [4:0] GAIN_WIDE = 5'h01;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam int MOD_W = 11;
    localparam int LOCK_W = 12;
    localparam int HALF_W = 7;

    typedef struct packed {
        logic pair_two;
        logic range_wide;
    } pcasr_cfg_t;

    typedef enum logic [2:0] {
        ST_OFF, ST_LOCK, ST_CONV, ST_UPD, ST_RDY, ST_SHIFT
    } pcasr_state_t;
endpackage

// ===== core/pcasr_top.sv
`timescale 1ns/1ps
module pcasr_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic push, pop;

    always_comb begin
        in_ready_o = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
        out_valid_o = wp_ff != rp_ff;
        out_data_o = mem_ff[rp_ff[AW-1:0]];
        push = in_valid_i & in_ready_o;
        pop = out_valid_o & out_ready_i;
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= in_data_i;
        end
    end
endmodule

module pcasr_top
    import pcasr_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYC_DEF,
    parameter int CNT_W = 21,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    // Configuration pins
    input wire logic cs_n_i,
    input wire logic mode_slave_i,
    input wire logic input_pair_select_i,
    input wire logic range_i,
    // Serial clock pin
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    // Data out / ready pin
    output logic dout_rdy_o,
    output logic dout_rdy_oe_o,
    // Filtered samples, signed
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire logic [RES_W-1:0] sample_data_i,
    // Analog front-end controls
    output logic input_pair_two_o,
    output logic [4:0] gain_amplifier_o,
    output logic mod_strobe_o,
    output logic pll_locked_o
);
    // Offset binary from two's complement
    function automatic logic [RES_W-1:0] to_offset(
        input logic [RES_W-1:0] s);
        return {~s[RES_W-1], s[RES_W-2:0]};
    endfunction

    // Pin synchronisers: cs, mode, pair, range, sclk
    logic [4:0] sync1_ff, sync2_ff;
    logic sclk_d_ff;
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            sync1_ff <= 5'h1D;
            sync2_ff <= 5'h1D;
            sclk_d_ff <= 1'b1;
        end else begin
            sync1_ff <= {cs_n_i, mode_slave_i, input_pair_select_i,
                         range_i, sclk_i};
            sync2_ff <= sync1_ff;
            sclk_d_ff <= sync2_ff[0];
        end
    end

    logic cs_n, slave;
    pcasr_cfg_t cfg;
    always_comb begin
        cs_n = sync2_ff[4];
        slave = sync2_ff[3];
        cfg.pair_two = sync2_ff[2];
        cfg.range_wide = sync2_ff[1];
    end

    logic fifo_valid, fifo_pop;
    logic [RES_W-1:0] fifo_data;
    pcasr_fifo #(.W(RES_W), .DEPTH(DEPTH)) u_fifo (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .in_data_i(sample_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    pcasr_state_t st_ff, nxt_st;
    pcasr_cfg_t cfg_ff, nxt_cfg;
    logic [CNT_W-1:0] conv_ff, nxt_conv;
    logic [MOD_W-1:0] mod_ff, nxt_mod;
    logic [LOCK_W-1:0] lock_ff, nxt_lock;
    logic [HALF_W-1:0] half_ff, nxt_half;
    logic [4:0] bit_ff, nxt_bit;
    logic [RES_W-1:0] shreg_ff, nxt_shreg;
    logic [1:0] settle_ff, nxt_settle;
    logic dout_ff, nxt_dout, sclk_ff, nxt_sclk, strobe_ff, nxt_strobe;
    logic active, conv_done, fall_ev, rise_ev, half_done;

    always_comb begin
        nxt_st = st_ff;
        nxt_cfg = cfg;
        nxt_conv = conv_ff;
        nxt_mod = mod_ff;
        nxt_lock = lock_ff;
        nxt_half = half_ff;
        nxt_bit = bit_ff;
        nxt_shreg = shreg_ff;
        nxt_settle = settle_ff;
        nxt_dout = dout_ff;
        nxt_sclk = sclk_ff;
        nxt_strobe = 1'b0;
        fifo_pop = 1'b0;
        active = st_ff != ST_OFF && st_ff != ST_LOCK;
        conv_done = conv_ff == CNT_W'(CONV_CYC - 1);
        half_done = half_ff == HALF_W'(HALF_CYC - 1);
        // Edge events, master from own timer, slave from host clock
        if (!slave) begin
            fall_ev = half_done && sclk_ff && st_ff == ST_RDY ||
                      half_done && sclk_ff && st_ff == ST_SHIFT;
            rise_ev = half_done && !sclk_ff && st_ff == ST_SHIFT;
        end else begin
            fall_ev = sclk_d_ff && !sync2_ff[0] &&
                      (st_ff == ST_RDY || st_ff == ST_SHIFT);
            rise_ev = !sclk_d_ff && sync2_ff[0] && st_ff == ST_SHIFT;
        end
        if (cs_n) begin
            nxt_st = ST_OFF;
            nxt_dout = 1'b1;
            nxt_sclk = 1'b1;
            nxt_shreg = '0;
            nxt_settle = SETTLE_PERIODS;
        end else begin
            if (active) begin
                nxt_conv = conv_done ? '0 : conv_ff + 1'b1;
                // Modulator runs at the crystal rate
                nxt_mod = mod_ff == MOD_W'(MOD_CYC - 1) ? '0 :
                          mod_ff + 1'b1;
                nxt_strobe = mod_ff == MOD_W'(MOD_CYC - 1);
            end
            case (st_ff)
                ST_OFF: begin
                    nxt_st = ST_LOCK;
                    nxt_lock = '0;
                end
                ST_LOCK: begin
                    nxt_lock = lock_ff + 1'b1;
                    if (lock_ff == LOCK_W'(LOCK_CYC - 1)) begin
                        nxt_st = ST_CONV;
                        nxt_conv = '0;
                        nxt_mod = '0;
                    end
                end
                ST_UPD: begin
                    fifo_pop = 1'b1;
                    nxt_shreg = to_offset(fifo_data);
                    nxt_dout = 1'b0;
                    nxt_st = ST_RDY;
                    nxt_bit = '0;
                    nxt_half = '0;
                end
                ST_RDY, ST_SHIFT: begin
                    nxt_half = half_done ? '0 : half_ff + 1'b1;
                    if (fall_ev) begin
                        nxt_dout = shreg_ff[RES_W-1];
                        nxt_shreg = {shreg_ff[RES_W-2:0], 1'b0};
                        nxt_st = ST_SHIFT;
                        nxt_sclk = slave ? sclk_ff : 1'b0;
                    end else if (rise_ev) begin
                        nxt_sclk = 1'b1;
                        nxt_bit = bit_ff + 1'b1;
                        if (bit_ff == LAST_BIT) begin
                            // Last bit stays through the rising edge
                            nxt_st = ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    // Ready returns high a clock after the last rise
                    nxt_dout = 1'b1;
                end
                default: begin
                end
            endcase
            if (active && conv_done) begin
                if (settle_ff != 2'h0) begin
                    nxt_settle = settle_ff - 1'b1;
                    fifo_pop = fifo_valid;
                end else if (fifo_valid) begin
                    // Ready high first, register loads next cycle
                    nxt_st = ST_UPD;
                    nxt_dout = 1'b1;
                    nxt_sclk = 1'b1;
                end
            end
            if (active && cfg != cfg_ff &&
                cfg.pair_two != cfg_ff.pair_two) begin
                nxt_settle = SETTLE_PERIODS;
                nxt_conv = '0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            st_ff <= ST_OFF;
            cfg_ff <= '0;
            conv_ff <= '0;
            mod_ff <= '0;
            lock_ff <= '0;
            half_ff <= '0;
            bit_ff <= '0;
            shreg_ff <= '0;
            settle_ff <= SETTLE_PERIODS;
            dout_ff <= 1'b1;
            sclk_ff <= 1'b1;
            strobe_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cfg_ff <= nxt_cfg;
            conv_ff <= nxt_conv;
            mod_ff <= nxt_mod;
            lock_ff <= nxt_lock;
            half_ff <= nxt_half;
            bit_ff <= nxt_bit;
            shreg_ff <= nxt_shreg;
            settle_ff <= nxt_settle;
            dout_ff <= nxt_dout;
            sclk_ff <= nxt_sclk;
            strobe_ff <= nxt_strobe;
        end
    end

    always_comb begin
        dout_rdy_o = dout_ff;
        sclk_o = sclk_ff;
        dout_rdy_oe_o = !cs_n;
        sclk_oe_o = !cs_n && !slave;
        input_pair_two_o = cfg_ff.pair_two;
        gain_amplifier_o = cfg_ff.range_wide ? GAIN_WIDE
                                             : GAIN_NARROW;
        mod_strobe_o = strobe_ff;
        pll_locked_o = active;
    end
endmodule

// ===== sim/pcasr_top_chk.sv
`timescale 1ns/1ps
module pcasr_top_chk
    import pcasr_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic mode_slave_i,
    input wire logic input_pair_select_i,
    input wire logic range_i,
    input wire logic sclk_o,
    input wire logic sclk_oe_o,
    input wire logic dout_rdy_o,
    input wire logic dout_rdy_oe_o,
    input wire logic input_pair_two_o,
    input wire logic [4:0] gain_amplifier_o,
    input wire logic mod_strobe_o
);
    logic [4:0] n_rise_ff;
    logic [4:0] nxt_n_rise;
    logic sclk_q_ff;
    logic dout_q_ff;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // Rising clock edges since ready went low, current edge included
    always_comb begin
        nxt_n_rise = n_rise_ff;
        if (dout_q_ff && !dout_rdy_o && sclk_o) begin
            nxt_n_rise = 5'h00;
        end else if (!sclk_q_ff && sclk_o && sclk_oe_o) begin
            nxt_n_rise = n_rise_ff + 5'h01;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            n_rise_ff <= 5'h00;
            sclk_q_ff <= 1'b1;
            dout_q_ff <= 1'b1;
        end else begin
            n_rise_ff <= nxt_n_rise;
            sclk_q_ff <= sclk_o;
            dout_q_ff <= dout_rdy_o;
        end
    end
    a_cs_release: assert property (
        cs_n_i [*5] |-> !dout_rdy_oe_o && !sclk_oe_o)
        else $error("pins not released");
    a_master_clk: assert property (
        (!cs_n_i && !mode_slave_i) [*5] |-> sclk_oe_o)
        else $error("master clock not driven");
    a_gain_map: assert property (
        $stable(range_i) [*5] |->
        gain_amplifier_o == (range_i ? GAIN_WIDE : GAIN_NARROW))
        else $error("gain mismatch");
    a_pair_map: assert property (
        $stable(input_pair_select_i) [*5] |->
        input_pair_two_o == input_pair_select_i)
        else $error("pair mismatch");
    a_lead_time: assert property (
        !mode_slave_i && sclk_oe_o && sclk_o && $fell(dout_rdy_o) |->
        ##77 sclk_o ##[1:5] !sclk_o)
        else $error("first clock fall late");
    a_idle_high: assert property (
        sclk_oe_o && sclk_o && $rose(dout_rdy_o) |-> sclk_o [*8])
        else $error("clock not idling high");
    a_data_hold: assert property (
        sclk_oe_o && !sclk_o && !$past(sclk_o) |-> $stable(dout_rdy_o))
        else $error("data changed while clock low");
    a_word_full: assert property (
        !mode_slave_i && sclk_oe_o && sclk_o && $rose(dout_rdy_o) &&
        nxt_n_rise != 5'h00 |-> nxt_n_rise == 5'h18)
        else $error("word edge count wrong");
    a_strobe_pulse: assert property (
        mod_strobe_o |=> !mod_strobe_o [*8])
        else $error("strobe too long");
endmodule
bind pcasr_top pcasr_top_chk i_pcasr_top_chk (.clock_i(clock_i),
    .nrst_i(nrst_i), .cs_n_i(cs_n_i), .mode_slave_i(mode_slave_i),
    .input_pair_select_i(input_pair_select_i), .range_i(range_i),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .dout_rdy_o(dout_rdy_o),
    .dout_rdy_oe_o(dout_rdy_oe_o), .input_pair_two_o(input_pair_two_o),
    .gain_amplifier_o(gain_amplifier_o), .mod_strobe_o(mod_strobe_o));

// ===== sim/pcasr_host.sv
`timescale 1ns/1ps
module pcasr_host
    import pcasr_pkg::*;
(
    input wire logic clock_i,
    input wire logic cs_n_i,
    input wire logic slave_i,
    input wire logic sclk_pin_i,
    input wire logic dout_i,
    output logic sclk_o,
    output logic word_valid_o,
    output logic [RES_W-1:0] word_o
);
    logic busy = 1'b0;
    logic done = 1'b0;
    logic d_q = 1'b1;
    logic c_q = 1'b1;
    int tmr = 0;
    int gen = 0;
    int got = 0;
    initial sclk_o = 1'b1;
    initial word_valid_o = 1'b0;
    initial word_o = 24'h000000;
    always @(posedge clock_i) begin
        d_q <= dout_i;
        c_q <= sclk_pin_i;
        word_valid_o <= 1'b0;
        if (cs_n_i) begin
            busy <= 1'b0;
            done <= 1'b0;
            sclk_o <= 1'b1;
        end else if (done) begin
            done <= !dout_i;
        end else if (!busy) begin
            // Two lows in a row: a released line never stays put
            if (!dout_i && !d_q && sclk_pin_i) begin
                busy <= 1'b1;
                tmr <= 4;
                gen <= 0;
                got <= 0;
            end
        end else begin
            if (!c_q && sclk_pin_i) begin
                word_o <= {word_o[RES_W-2:0], dout_i};
                got <= got + 1;
                if (got == RES_W - 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    word_valid_o <= 1'b1;
                end
            end
            if (slave_i && gen < RES_W) begin
                if (tmr != 0) begin
                    tmr <= tmr - 1;
                end else if (sclk_o) begin
                    sclk_o <= 1'b0;
                    tmr <= 3;
                end else begin
                    sclk_o <= 1'b1;
                    gen <= gen + 1;
                    tmr <= (gen % 8 == 7) ? 40 : 3;
                end
            end
        end
    end
endmodule

// ===== sim/tb_pcasr_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((e) !== (g)) begin \
            n_mismatch++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_pcasr_top;
    import pcasr_pkg::*;
    localparam int CONV = 3900;
    localparam int LIMIT = 97000;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cs_n_i = 1'b1;
    logic mode = 1'b0;
    logic pair_sel = 1'b0;
    logic range_i = 1'b0;
    logic s_valid = 1'b0;
    logic [RES_W-1:0] s_data = 24'h000000;
    logic flip = 1'b0;
    logic sclk_o, sclk_oe, dout_o, dout_oe, s_ready, pair_two, h_sclk, w_valid;
    logic locked;
    logic [4:0] gain;
    logic [RES_W-1:0] word, e_w;
    logic [RES_W-1:0] exp_q[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire sclk_pin = sclk_oe ? sclk_o : (mode ? h_sclk : flip);
    wire dout_pin = dout_oe ? dout_o : flip;
    initial forever #12.5 clock_i = ~clock_i;
    pcasr_top #(.CONV_CYC(CONV)) i_pcasr_top (.clock_i(clock_i),
        .nrst_i(nrst_i), .cs_n_i(cs_n_i), .mode_slave_i(mode),
        .input_pair_select_i(pair_sel), .range_i(range_i),
        .sclk_i(sclk_pin), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe),
        .dout_rdy_o(dout_o), .dout_rdy_oe_o(dout_oe),
        .sample_valid_i(s_valid), .sample_ready_o(s_ready),
        .sample_data_i(s_data), .input_pair_two_o(pair_two),
        .gain_amplifier_o(gain), .mod_strobe_o(), .pll_locked_o(locked));
    pcasr_host i_pcasr_host (.clock_i(clock_i), .cs_n_i(cs_n_i),
        .slave_i(mode), .sclk_pin_i(sclk_pin), .dout_i(dout_pin),
        .sclk_o(h_sclk), .word_valid_o(w_valid), .word_o(word));
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        flip <= ~flip;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end
    always @(posedge clock_i) begin
        if (w_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("spare word", 1'b0, w_valid)
            end else begin
                e_w = exp_q.pop_front();
                `CHK("word", e_w, word)
            end
        end
    end
    // First two words after select fall inside settling and are dropped
    task automatic run(input logic m, input int n);
        logic [RES_W-1:0] s;
        cs_n_i <= 1'b1;
        mode <= m;
        pair_sel <= m;
        range_i <= m;
        repeat (8) @(posedge clock_i);
        `CHK("released", 2'b00, {dout_oe, sclk_oe})
        cs_n_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            s = RES_W'($urandom);
            s_data <= s;
            s_valid <= 1'b1;
            if (i >= 2) exp_q.push_back({~s[RES_W-1], s[RES_W-2:0]});
            @(posedge clock_i);
        end
        s_valid <= 1'b0;
        @(negedge clock_i);
        `CHK("fifo ready", 1'(n < FIFO_DEPTH), s_ready)
        `CHK("lock wait", 1'b0, locked)
        `CHK("clock drive", !m, sclk_oe)
        `CHK("gain", m ? GAIN_WIDE : GAIN_NARROW, gain)
        `CHK("pair", m, pair_two)
        while (exp_q.size() != 0) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        `CHK("ready idle", 1'b1, dout_pin)
        `CHK("locked", 1'b1, locked)
        @(posedge clock_i);
    endtask
    initial begin
        void'($urandom(32'hFAB8));
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        run(1'b0, 3);
        run(1'b1, 16);
        conclude();
    end
endmodule
